// ---- hdl/jtl_defines.vh ----
// Register offsets, field positions, resets and timing for the link config
`ifndef JTL_DEFINES_VH
`define JTL_DEFINES_VH
// Register byte offsets (printed offsets kept as indices, address = 4*index)
`define JTL_IDX_CONV_COUNT    10'h1C6
`define JTL_IDX_SAMP_FRAME    10'h1C9
`define JTL_IDX_SPARE_ONE     10'h1CB
`define JTL_IDX_SPARE_TWO     10'h1CC
`define JTL_IDX_LANE0_ID      10'h1D0
`define JTL_IDX_LANE1_ID      10'h1D1
`define JTL_IDX_LANE0_CHK     10'h1D8
`define JTL_IDX_LANE1_CHK     10'h1D9
`define JTL_IDX_FIFO_START    10'h1E0
`define JTL_IDX_SRC_ROUTE     10'h1E1
`define JTL_IDX_PD_DELAY      10'h1E2
`define JTL_IDX_IF_CTRL0      10'h1E3
`define JTL_IDX_FRAMES_MF     10'h1C5
`define JTL_IDX_REPEAT_CNT    10'h1E6
// Reset values
`define JTL_RST_CONV_COUNT    8'h01
`define JTL_RST_SAMP_FRAME    8'h00
`define JTL_RST_SPARE         8'h00
`define JTL_RST_LANE0_ID      8'h00
`define JTL_RST_LANE1_ID      8'h01
`define JTL_RST_LANE0_CHK     8'h44
`define JTL_RST_LANE1_CHK     8'h45
`define JTL_RST_FIFO_START    8'h00
`define JTL_RST_SRC_ROUTE     8'h00
`define JTL_RST_PD_DELAY      8'h00
`define JTL_RST_IF_CTRL0      8'h14
`define JTL_RST_FRAMES_MF     8'h1F
`define JTL_RST_REPEAT_CNT    8'h00
// Writable masks (reserved bits kept at zero)
`define JTL_MSK_SAMP_FRAME    8'h1F
`define JTL_MSK_LANE_ID       8'h1F
`define JTL_MSK_FIFO_START    8'h01
`define JTL_MSK_SRC_ROUTE     8'h33
`define JTL_MSK_PD_DELAY      8'hF3
`define JTL_MSK_IF_CTRL0      8'h3E
`define JTL_MSK_FRAMES_MF     8'h1F
// Field positions
`define JTL_BIT_FIFO_START    0
`define JTL_BIT_CONV0_SWAP    4
`define JTL_BIT_CONV1_SWAP    5
`define JTL_BIT_LANE0_SWAP    0
`define JTL_BIT_LANE1_SWAP    1
`define JTL_BIT_TEST_SAMPLE   5
`define JTL_BIT_LANE_SYNC     4
`define JTL_BIT_ALIGN_OFF     1
`define JTL_ALIGN_MODE_LO     2
`define JTL_ALIGN_MODE_NORMAL 2'b01
`define JTL_ALIGN_MODE_ALWAYS 2'b11
// Octets per frame used for multiframe timing (fixed by neighbour register)
`define JTL_OCTETS_PER_FRAME  4'h4
`endif

// ---- hdl/jtl_lmfc_timer.v ----
// Multiframe (LMFC) edge generator counting octet clocks per multiframe
`timescale 1ns/1ps
`default_nettype none
`include "jtl_defines.vh"
module jtl_lmfc_timer (
   input  wire       i_clk,      // Link clock, one octet per edge
   input  wire       i_rst_b,    // Async reset, active low
   input  wire [4:0] i_frames,   // Frames per multiframe minus one
   output reg        o_lmfc_edge // One-cycle pulse per multiframe start
);
   reg [1:0] oct_cnt;
   reg [4:0] frm_cnt;
   wire      last_oct = (oct_cnt == 2'h3);

   // Octet then frame counters; wrap marks a multiframe edge
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         oct_cnt     <= 2'h0;
         frm_cnt     <= 5'h00;
         o_lmfc_edge <= 1'b0;
      end else begin
         oct_cnt     <= oct_cnt + 2'h1;
         o_lmfc_edge <= 1'b0;
         if (last_oct) begin
            if (frm_cnt >= i_frames) begin
               frm_cnt     <= 5'h00;
               o_lmfc_edge <= 1'b1;
            end else begin
               frm_cnt <= frm_cnt + 5'h01;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- hdl/jtl_link_config.v ----
// Link configuration registers, APB slave, routing and ILAS sequencing
//
// Functional notes
// - Converter-count register resets to 0x01, advertising two converters.
// - Samples-per-frame holds 00000; software must write nothing else.
// - Per-lane writable checksums reset to 0x44 and 0x45.
// - Lane FIFO hand-off runs only while the start bit is set.
// - Source bit 4 picks converter 0 feed: 0 is I, 1 is Q.
// - Source bit 5 picks converter 1 feed: 0 is Q, 1 is I.
// - Lane bit 0 set makes framer lane 1 drive output lane 0.
// - Lane bit 1 set makes framer lane 0 drive output lane 1.
// - Zero delay: ILAS starts on first LMFC edge after sync release.
// - Delay field bits 7:4 postpones ILAS by whole multiframes.
// - Power-down bits 1:0 power down lane PHYs; reset powered.
// - Control bit 5 sends transport test samples instead of data.
// - Control bit 4 enables lane synchronization; resets to one.
// - Mode 01 normal Alignment_seq_mode 11 sends ILAS continuously.
// - Control bit 1 stops frame alignment character insertion.
// - Multiframe holds frames-per-multiframe register value plus one.
// - ILAS is sent repeat-count register value plus one times.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "jtl_defines.vh"
module jtl_link_config (
   input  wire        i_clk,             // 125 MHz link clock
   input  wire        i_rst_b,           // Async reset, active low
   input  wire        i_psel,            // APB select
   input  wire        i_penable,         // APB access phase
   input  wire        i_pwrite,          // APB direction, 1 = write
   input  wire [11:0] i_paddr,           // APB byte address
   input  wire [31:0] i_pwdata,          // APB write data
   output wire        o_pready,          // APB ready, always high
   output reg  [31:0] o_prdata,          // APB read data
   output wire        o_pslverr,         // APB error on unmapped address
   input  wire [15:0] i_sample_i,        // I channel sample
   input  wire [15:0] i_sample_q,        // Q channel sample
   input  wire [15:0] i_test_sample,     // Transport test sample
   input  wire        i_link_sync_request_n, // Sync request pin, low active
   input  wire [31:0] i_framer_lane0,    // Framer lane 0 octets
   input  wire [31:0] i_framer_lane1,    // Framer lane 1 octets
   output reg  [15:0] o_conv0_data,      // Framer converter 0 input
   output reg  [15:0] o_conv1_data,      // Framer converter 1 input
   output reg  [31:0] o_phy_lane0,       // Physical output lane 0
   output reg  [31:0] o_phy_lane1,       // Physical output lane 1
   output reg         o_lane_fifo_run,   // Lane FIFO hand-off running
   output reg  [1:0]  o_lane_phy_powerdown, // Per-lane PHY power-down
   output reg         o_ilas_active,     // Framer sends ILAS now
   output reg         o_data_active,     // Framer sends user data now
   output reg         o_test_sample_en,  // Transport test samples on
   output reg         o_align_char_insert_off, // Alignment chars off
   output reg         o_lane_sync_enable // Lane synchronization on
);
   // Sync state codes
   localparam ST_WAIT  = 2'h0;
   localparam ST_DELAY = 2'h1;
   localparam ST_ILAS  = 2'h2;
   localparam ST_DATA  = 2'h3;

   // Register file, one byte each
   reg  [7:0] converter_count_param;
   reg  [7:0] samples_per_frame_param;
   reg  [7:0] spare_param_byte_one;
   reg  [7:0] spare_param_byte_two;
   reg  [7:0] lane0_identifier;
   reg  [7:0] lane1_identifier;
   reg  [7:0] lane0_checksum;
   reg  [7:0] lane1_checksum;
   reg  [7:0] lane_fifo_start;
   reg  [7:0] source_routing;
   reg  [7:0] lane_powerdown_alignment_seq_start_delay;
   reg  [7:0] interface_control_zero;
   reg  [7:0] frames_per_multiframe;
   reg  [7:0] alignment_seq_repeat_count;

   // Sync pin synchroniser
   reg        sync_meta;
   reg        sync_pin;

   // Sequencer state and counters
   reg  [1:0] state;
   reg  [1:0] next_state;
   reg  [3:0] delay_cnt;
   reg  [3:0] next_delay_cnt;
   reg  [9:0] rep_cnt;
   reg  [9:0] next_rep_cnt;

   // Bus decode
   reg  [7:0] rd_byte;
   reg        addr_hit;
   wire       lmfc_edge;
   wire       wr_en;
   wire       rd_en;
   wire [9:0] idx;
   wire [7:0] wb;
   wire       sync_released;
   wire [1:0] align_mode;
   wire       conv0_swap;
   wire       conv1_swap;
   wire       lane0_swap;
   wire       lane1_swap;

   // APB strobes and field taps
   assign idx        = i_paddr[11:2];
   assign wb         = i_pwdata[7:0];
   assign wr_en      = i_psel & i_penable & i_pwrite;
   // Setup loads read data for the access
   assign rd_en      = i_psel & ~i_penable & ~i_pwrite;
   assign o_pready   = 1'b1;
   assign o_pslverr  = i_psel & i_penable & ~addr_hit;
   assign align_mode = interface_control_zero[`JTL_ALIGN_MODE_LO+1:
                                              `JTL_ALIGN_MODE_LO];
   assign conv0_swap = source_routing[`JTL_BIT_CONV0_SWAP];
   assign conv1_swap = source_routing[`JTL_BIT_CONV1_SWAP];
   assign lane0_swap = source_routing[`JTL_BIT_LANE0_SWAP];
   assign lane1_swap = source_routing[`JTL_BIT_LANE1_SWAP];

   // Read mux and address decode
   always @* begin
      addr_hit = 1'b1;
      rd_byte  = 8'h00;
      case (idx)
         `JTL_IDX_CONV_COUNT: rd_byte = converter_count_param;
         `JTL_IDX_SAMP_FRAME: rd_byte = samples_per_frame_param;
         `JTL_IDX_SPARE_ONE:  rd_byte = spare_param_byte_one;
         `JTL_IDX_SPARE_TWO:  rd_byte = spare_param_byte_two;
         `JTL_IDX_LANE0_ID:   rd_byte = lane0_identifier;
         `JTL_IDX_LANE1_ID:   rd_byte = lane1_identifier;
         `JTL_IDX_LANE0_CHK:  rd_byte = lane0_checksum;
         `JTL_IDX_LANE1_CHK:  rd_byte = lane1_checksum;
         `JTL_IDX_FIFO_START: rd_byte = lane_fifo_start;
         `JTL_IDX_SRC_ROUTE:  rd_byte = source_routing;
         `JTL_IDX_PD_DELAY:   rd_byte = lane_powerdown_alignment_seq_start_delay;
         `JTL_IDX_IF_CTRL0:   rd_byte = interface_control_zero;
         `JTL_IDX_FRAMES_MF:  rd_byte = frames_per_multiframe;
         `JTL_IDX_REPEAT_CNT: rd_byte = alignment_seq_repeat_count;
         default:             addr_hit = 1'b0;
      endcase
   end

   // Register writes; reserved bits masked off
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         converter_count_param      <= `JTL_RST_CONV_COUNT;
         samples_per_frame_param    <= `JTL_RST_SAMP_FRAME;
         spare_param_byte_one       <= `JTL_RST_SPARE;
         spare_param_byte_two       <= `JTL_RST_SPARE;
         lane0_identifier           <= `JTL_RST_LANE0_ID;
         lane1_identifier           <= `JTL_RST_LANE1_ID;
         lane0_checksum             <= `JTL_RST_LANE0_CHK;
         lane1_checksum             <= `JTL_RST_LANE1_CHK;
         lane_fifo_start            <= `JTL_RST_FIFO_START;
         source_routing             <= `JTL_RST_SRC_ROUTE;
         lane_powerdown_alignment_seq_start_delay  <= `JTL_RST_PD_DELAY;
         interface_control_zero     <= `JTL_RST_IF_CTRL0;
         frames_per_multiframe      <= `JTL_RST_FRAMES_MF;
         alignment_seq_repeat_count <= `JTL_RST_REPEAT_CNT;
      end else if (wr_en) begin
         case (idx)
            // Parameters and spares
            `JTL_IDX_CONV_COUNT: converter_count_param <= wb;
            `JTL_IDX_SAMP_FRAME:
               samples_per_frame_param <= wb & `JTL_MSK_SAMP_FRAME;
            `JTL_IDX_SPARE_ONE:  spare_param_byte_one <= wb;
            `JTL_IDX_SPARE_TWO:  spare_param_byte_two <= wb;
            // Lane identities, checksums
            `JTL_IDX_LANE0_ID:   lane0_identifier <= wb & `JTL_MSK_LANE_ID;
            `JTL_IDX_LANE1_ID:   lane1_identifier <= wb & `JTL_MSK_LANE_ID;
            `JTL_IDX_LANE0_CHK:  lane0_checksum <= wb;
            `JTL_IDX_LANE1_CHK:  lane1_checksum <= wb;
            // Hand-off, routing, control
            `JTL_IDX_FIFO_START:
               lane_fifo_start <= wb & `JTL_MSK_FIFO_START;
            `JTL_IDX_SRC_ROUTE:
               source_routing <= wb & `JTL_MSK_SRC_ROUTE;
            `JTL_IDX_PD_DELAY:
               lane_powerdown_alignment_seq_start_delay <= wb & `JTL_MSK_PD_DELAY;
            `JTL_IDX_IF_CTRL0:
               interface_control_zero <= wb & `JTL_MSK_IF_CTRL0;
            `JTL_IDX_FRAMES_MF:
               frames_per_multiframe <= wb & `JTL_MSK_FRAMES_MF;
            `JTL_IDX_REPEAT_CNT: alignment_seq_repeat_count <= wb;
            default: ;
         endcase
      end
   end

   // Registered read data, loaded in the setup phase
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_prdata <= 32'h00000000;
      end else if (rd_en) begin
         o_prdata <= {24'h000000, rd_byte};
      end
   end

   // Two-stage synchroniser for the sync request pin
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync_meta <= 1'b0;
         sync_pin  <= 1'b0;
      end else begin
         sync_meta <= i_link_sync_request_n;
         sync_pin  <= sync_meta;
      end
   end

   // High level releases the request; low requests sync
   assign sync_released = sync_pin;

   // Multiframe edge timer
   jtl_lmfc_timer u_lmfc (
      .i_clk       (i_clk),
      .i_rst_b     (i_rst_b),
      .i_frames    (frames_per_multiframe[4:0]),
      .o_lmfc_edge (lmfc_edge)
   );

   // ILAS sequencing per multiframe
   always @* begin
      next_state     = state;
      next_delay_cnt = delay_cnt;
      next_rep_cnt   = rep_cnt;
      case (state)
         // Await release and an LMFC edge
         ST_WAIT: begin
            if (sync_released && lmfc_edge) begin
               next_rep_cnt = 10'h000;
               if (lane_powerdown_alignment_seq_start_delay[7:4] == 4'h0) begin
                  next_state = ST_ILAS;
               end else begin
                  next_delay_cnt = lane_powerdown_alignment_seq_start_delay[7:4] - 4'h1;
                  next_state     = ST_DELAY;
               end
            end
         end

         // Whole multiframes of delay
         ST_DELAY: begin
            if (!sync_released) begin
               next_state = ST_WAIT;
            end else if (lmfc_edge) begin
               if (delay_cnt == 4'h0) begin
                  next_state = ST_ILAS;
               end else begin
                  next_delay_cnt = delay_cnt - 4'h1;
               end
            end
         end

         // Passes; mode 11 never leaves
         ST_ILAS: begin
            if (!sync_released &&
                align_mode != `JTL_ALIGN_MODE_ALWAYS) begin
               next_state = ST_WAIT;
            end else if (lmfc_edge &&
                         align_mode != `JTL_ALIGN_MODE_ALWAYS) begin
               // Four multiframes per pass
               if (rep_cnt ==
                   {alignment_seq_repeat_count, 2'b11}) begin
                  next_state = ST_DATA;
               end else begin
                  next_rep_cnt = rep_cnt + 10'h001;
               end
            end
         end

         // Resync if lane sync is on
         ST_DATA: begin
            if (!sync_released && o_lane_sync_enable) begin
               next_state = ST_WAIT;
            end
         end
         default: next_state = ST_WAIT;
      endcase
   end

   // State registers; mode other than 01/11 skips ILAS
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state     <= ST_WAIT;
         delay_cnt <= 4'h0;
         rep_cnt   <= 10'h000;
      end else if (next_state == ST_ILAS && align_mode[0] == 1'b0) begin
         // Bit 0 clear skips the ILAS state
         state     <= ST_DATA;
         delay_cnt <= next_delay_cnt;
         rep_cnt   <= next_rep_cnt;
      end else begin
         state     <= next_state;
         delay_cnt <= next_delay_cnt;
         rep_cnt   <= next_rep_cnt;
      end
   end

   // Data path: source routing, lane routing and control outputs
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_conv0_data            <= 16'h0000;
         o_conv1_data            <= 16'h0000;
         o_phy_lane0             <= 32'h00000000;
         o_phy_lane1             <= 32'h00000000;
         o_lane_fifo_run         <= 1'b0;
         o_lane_phy_powerdown    <= 2'h0;
         o_ilas_active           <= 1'b0;
         o_data_active           <= 1'b0;
         o_test_sample_en        <= 1'b0;
         o_align_char_insert_off <= 1'b0;
         o_lane_sync_enable      <= 1'b1;
      end else begin
         // Converter feeds, test override
         if (interface_control_zero[`JTL_BIT_TEST_SAMPLE]) begin
            o_conv0_data <= i_test_sample;
            o_conv1_data <= i_test_sample;
         end else begin
            o_conv0_data <= conv0_swap ? i_sample_q : i_sample_i;
            o_conv1_data <= conv1_swap ? i_sample_i : i_sample_q;
         end

         // Lane hand-off, held when stopped
         o_lane_fifo_run <= lane_fifo_start[`JTL_BIT_FIFO_START];
         if (lane_fifo_start[`JTL_BIT_FIFO_START]) begin
            o_phy_lane0 <= lane0_swap ? i_framer_lane1
                                      : i_framer_lane0;
            o_phy_lane1 <= lane1_swap ? i_framer_lane0
                                      : i_framer_lane1;
         end

         // Control and state levels
         o_lane_phy_powerdown    <= lane_powerdown_alignment_seq_start_delay[1:0];
         o_ilas_active           <= (state == ST_ILAS);
         o_data_active           <= (state == ST_DATA);
         o_test_sample_en        <=
            interface_control_zero[`JTL_BIT_TEST_SAMPLE];
         o_align_char_insert_off <=
            interface_control_zero[`JTL_BIT_ALIGN_OFF];
         o_lane_sync_enable      <=
            interface_control_zero[`JTL_BIT_LANE_SYNC];
      end
   end
endmodule
`default_nettype wire

// ---- test/jtl_link_config_assertions.sv ----
// Port-level assertions for the link configuration block
`timescale 1ns/1ps
`default_nettype none
module jtl_link_config_chk (
   input wire logic        i_clk,                 // Clock
   input wire logic        i_rst_b,               // Reset, low
   input wire logic        i_psel,                // Select
   input wire logic        i_penable,             // Access
   input wire logic        i_pwrite,              // Direction
   input wire logic [11:0] i_paddr,               // Address
   input wire logic [31:0] i_framer_lane0,        // Framer lane 0
   input wire logic [31:0] i_framer_lane1,        // Framer lane 1
   input wire logic        i_link_sync_request_n, // Sync pin
   input wire logic        o_pslverr,             // Slave error
   input wire logic [31:0] o_prdata,              // Read data
   input wire logic [31:0] o_phy_lane0,           // Output lane 0
   input wire logic [31:0] o_phy_lane1,           // Output lane 1
   input wire logic        o_lane_fifo_run,       // FIFO running
   input wire logic [1:0]  o_lane_phy_powerdown,  // PHY power-down
   input wire logic        o_ilas_active,         // ILAS state
   input wire logic        o_data_active,         // Data state
   input wire logic        o_lane_sync_enable     // Lane sync on
);
   // Decode of the mapped register indices
   wire logic mapped = i_paddr[11:2] inside {10'h1C5, 10'h1C6, 10'h1C9,
      10'h1CB, 10'h1CC, 10'h1D0, 10'h1D1, 10'h1D8, 10'h1D9, 10'h1E0,
      10'h1E1, 10'h1E2, 10'h1E3, 10'h1E6};

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   fifo_hold_a: assert property (
      !$past(o_lane_fifo_run) && !o_lane_fifo_run
      |-> $stable(o_phy_lane0) && $stable(o_phy_lane1))
      else $error("phy lanes moved while lane FIFOs stopped");
   lane0_src_a: assert property (
      $past(o_lane_fifo_run) && o_lane_fifo_run
      |-> o_phy_lane0 == $past(i_framer_lane0)
       || o_phy_lane0 == $past(i_framer_lane1))
      else $error("output lane 0 not fed by a framer lane");
   lane1_src_a: assert property (
      $past(o_lane_fifo_run) && o_lane_fifo_run
      |-> o_phy_lane1 == $past(i_framer_lane1)
       || o_phy_lane1 == $past(i_framer_lane0))
      else $error("output lane 1 not fed by a framer lane");
   unmapped_err_a: assert property (
      i_psel && i_penable |-> o_pslverr == !mapped)
      else $error("slave error does not match address decode");
   unmapped_zero_a: assert property (
      i_psel && i_penable && !i_pwrite && !mapped |-> o_prdata == 32'h0)
      else $error("unmapped read returned nonzero data");
   ilas_sync_a: assert property (
      $rose(o_ilas_active) |-> $past(i_link_sync_request_n, 2))
      else $error("alignment sequence began without sync release");
   state_excl_a: assert property (
      !(o_ilas_active && o_data_active))
      else $error("alignment sequence and data sent together");
   resync_drop_a: assert property (
      (!i_link_sync_request_n && o_lane_sync_enable) [*6]
      |-> !o_data_active)
      else $error("data kept flowing under a sync request");
   pd_steady_a: assert property (
      !$past(i_psel && i_penable && i_pwrite)
      && !$past(i_psel && i_penable && i_pwrite, 2)
      |-> $stable(o_lane_phy_powerdown))
      else $error("power-down changed without a register write");
endmodule

bind jtl_link_config jtl_link_config_chk chk (.*);
`default_nettype wire

// ---- test/jtl_rx_model.sv ----
// Far-side receiver model driving the sync request pin
`timescale 1ns/1ps
`default_nettype none
module jtl_rx_model (
   input  wire logic i_clk,                 // Link clock
   input  wire logic i_rst_b,               // Reset, active low
   input  wire logic i_ready,               // Receiver ready to release
   input  wire logic i_slow,                // Release late when high
   output var  logic o_link_sync_request_n  // Low requests sync
);
   logic [2:0] lag;

   // Request sync until ready has lasted the chosen lag
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         lag <= 3'h0;
         o_link_sync_request_n <= 1'b0;
      end else if (!i_ready) begin
         lag <= 3'h0;
         o_link_sync_request_n <= 1'b0;
      end else begin
         lag <= (lag == 3'h7) ? lag : lag + 3'h1;
         o_link_sync_request_n <= lag >= (i_slow ? 3'h5 : 3'h0);
      end
   end
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the link configuration block
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        i_clk, i_rst_b, i_psel, i_penable, i_pwrite, o_pready;
   logic        o_pslverr, i_link_sync_request_n, o_lane_fifo_run;
   logic        o_ilas_active, o_data_active, o_test_sample_en;
   logic        o_align_char_insert_off, o_lane_sync_enable;
   logic        rx_ready, rx_slow;
   logic [1:0]  o_lane_phy_powerdown;
   logic [11:0] i_paddr;
   logic [15:0] i_sample_i, i_sample_q, i_test_sample;
   logic [15:0] o_conv0_data, o_conv1_data;
   logic [31:0] i_pwdata, o_prdata, i_framer_lane0, i_framer_lane1;
   logic [31:0] o_phy_lane0, o_phy_lane1;
   logic [7:0]  exp_q[$];
   int          errors, check_count;
   logic [9:0]  ri[14] = '{10'h1C6, 10'h1C9, 10'h1CB, 10'h1CC, 10'h1D0,
      10'h1D1, 10'h1D8, 10'h1D9, 10'h1E0, 10'h1E1, 10'h1E2, 10'h1E3,
      10'h1C5, 10'h1E6};
   logic [7:0]  rv[14] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
      8'h44, 8'h45, 8'h00, 8'h00, 8'h00, 8'h14, 8'h1F, 8'h00};
   logic [7:0]  rm[14] = '{8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'h1F, 8'h1F,
      8'hFF, 8'hFF, 8'h01, 8'h33, 8'hF3, 8'h3E, 8'h1F, 8'hFF};

   jtl_link_config dut (.*);
   jtl_rx_model rx (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ready(rx_ready),
      .i_slow(rx_slow), .o_link_sync_request_n(i_link_sync_request_n));

   // 125 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   // Watchdog against a hung run
   initial begin
      #400000;
      errors++;
      tally_and_finish();
   end

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic cmp(input string nm, input logic [31:0] e, s);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask

   // One APB transfer launched on a rising edge
   task automatic apb(input logic w, input logic [9:0] x,
                      input logic [7:0] d);
      @(posedge i_clk);
      i_psel   <= 1'b1;
      i_pwrite <= w;
      i_paddr  <= {x, 2'b00};
      i_pwdata <= {24'h000000, d};
      @(posedge i_clk);
      i_penable <= 1'b1;
      do @(posedge i_clk); while (o_pready !== 1'b1);
      i_psel    <= 1'b0;
      i_penable <= 1'b0;
   endtask

   task automatic rd(input logic [9:0] x, input logic [7:0] e);
      exp_q.push_back(e);
      apb(1'b0, x, 8'h00);
   endtask

   // Read data taken at the edge ending the access
   always @(posedge i_clk) begin
      if (i_psel && i_penable && !i_pwrite && o_pready === 1'b1)
         cmp("prdata", {24'h000000, exp_q.pop_front()}, o_prdata);
   end

   // Drop sync, release it, then time the alignment sequence
   task automatic link_run(input logic [3:0] dly, input logic [7:0] ctl,
                           output int w, output int n);
      apb(1'b1, 10'h1E2, {dly, 4'h0});
      apb(1'b1, 10'h1E3, ctl);
      rx_ready <= 1'b0;
      repeat (12) @(posedge i_clk);
      rx_ready <= 1'b1;
      rx_slow  <= 1'($urandom);
      w = 0;
      n = 0;
      while (i_link_sync_request_n !== 1'b1) @(negedge i_clk);
      while (o_ilas_active !== 1'b1 && w < 400) begin
         @(negedge i_clk);
         w++;
      end
      while (o_ilas_active === 1'b1 && n < 400) begin
         @(negedge i_clk);
         n++;
      end
   endtask

   initial begin
      int          w, n;
      logic [7:0]  v;
      logic [31:0] f0, f1;
      {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_sample_i,
       i_sample_q, i_test_sample, i_framer_lane0, i_framer_lane1,
       rx_ready, rx_slow} = '0;
      i_rst_b = 1'b0;
      void'($urandom(32'h0BE970CB));
      repeat (6) @(posedge i_clk);
      i_rst_b <= 1'b1;
      // Reset values, then an unmapped place
      for (int j = 0; j < 14; j++)
         rd(ri[j], rv[j]);
      rd(10'h1C7, 8'h00);
      cmp("lsync_rst", 1, 32'(o_lane_sync_enable));
      // Random writes read back through the writable masks
      for (int j = 0; j < 14; j++) begin
         v = (j == 1) ? 8'h00 : 8'($urandom);
         apb(1'b1, ri[j], v);
         rd(ri[j], v & rm[j]);
      end
      // Short multiframe, lane FIFOs started last
      apb(1'b1, 10'h1C5, 8'h01);
      apb(1'b1, 10'h1E6, 8'h01);
      apb(1'b1, 10'h1E3, 8'h14);
      apb(1'b1, 10'h1E2, 8'h00);
      apb(1'b1, 10'h1E0, 8'h01);
      // Every converter and lane source code
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, 10'h1E1, {2'b00, 2'(k), 2'b00, 2'(k)});
         i_sample_i     <= 16'($urandom);
         i_sample_q     <= 16'($urandom);
         i_test_sample  <= 16'($urandom);
         i_framer_lane0 <= $urandom;
         i_framer_lane1 <= $urandom;
         repeat (3) @(negedge i_clk);
         cmp("conv0", 32'(k[0] ? i_sample_q : i_sample_i),
             32'(o_conv0_data));
         cmp("conv1", 32'(k[1] ? i_sample_i : i_sample_q),
             32'(o_conv1_data));
         cmp("lane0", k[0] ? i_framer_lane1 : i_framer_lane0,
             o_phy_lane0);
         cmp("lane1", k[1] ? i_framer_lane0 : i_framer_lane1,
             o_phy_lane1);
      end
      // Stopped FIFOs freeze the physical lanes
      apb(1'b1, 10'h1E0, 8'h00);
      f0 = i_framer_lane1;
      f1 = i_framer_lane0;
      i_framer_lane0 <= ~f1;
      i_framer_lane1 <= ~f0;
      repeat (3) @(negedge i_clk);
      cmp("lane0_hold", f0, o_phy_lane0);
      cmp("lane1_hold", f1, o_phy_lane1);
      apb(1'b1, 10'h1E0, 8'h01);
      // Power-down codes and control bits
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, 10'h1E2, 8'(k));
         repeat (2) @(negedge i_clk);
         cmp("pd", 32'(k), 32'(o_lane_phy_powerdown));
      end
      apb(1'b1, 10'h1E3, 8'h26);
      repeat (2) @(negedge i_clk);
      cmp("test_en", 1, 32'(o_test_sample_en));
      cmp("lsync", 0, 32'(o_lane_sync_enable));
      cmp("align_off", 1, 32'(o_align_char_insert_off));
      cmp("conv0_test", 32'(i_test_sample), 32'(o_conv0_data));
      cmp("conv1_test", 32'(i_test_sample), 32'(o_conv1_data));
      // Alignment sequence with start delays of zero and two
      for (int k = 0; k < 3; k += 2) begin
         link_run(4'(k), 8'h14, w, n);
         cmp("ilas_wait", 1, 32'(w > k * 8 && w < k * 8 + 13));
         cmp("ilas_len", 64, n);
         cmp("data_on", 1, 32'(o_data_active));
      end
      link_run(4'h0, 8'h10, w, n);
      cmp("ilas_skip", 0, n);
      cmp("data_direct", 1, 32'(o_data_active));
      link_run(4'h0, 8'h1C, w, n);
      cmp("ilas_cont", 400, n);
      tally_and_finish();
   end
endmodule
`default_nettype wire
